// ---- hw/subblock_reset_and_powerup_seq.sv ----
// Sub-block reset control and power-up sequencing timer with AHB-Lite registers
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module subblock_reset_and_powerup_seq (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic select_pin,
    input wire logic data_io_pin,
    input wire logic pll_lock,
    input wire logic carrier_sense,
    input wire logic [7:0] subblock_clk_run,
    output logic adc_ctrl_restart_low,
    output logic gain_ctrl_restart_low,
    output logic shaping_filter_restart_low,
    output logic freq_track_restart_low,
    output logic modulator_sync_restart_low,
    output logic synthesizer_restart_low,
    output logic sequencer_restart_low,
    output logic cal_lock_restart_low,
    output logic synth_power_up,
    output logic rx_power_up
);
    restart_if rif ();

    logic [3:0] pin_level;
    logic [3:0] pin_fall;

    logic dp_valid_q;
    logic dp_valid_d;
    logic dp_write_q;
    logic dp_write_d;
    logic [11:0] dp_addr_q;
    logic [11:0] dp_addr_d;
    logic rd_wait_q;
    logic rd_wait_d;
    logic [31:0] hrdata_q;
    logic [31:0] hrdata_d;
    logic addr_accept;
    logic reg_write;

    logic [7:0] seq_cfg_q;
    logic [7:0] seq_cfg_d;
    logic [2:0] mode_ctrl_q;
    logic [2:0] mode_ctrl_d;

    logic [7:0] adc_div_q;
    logic [7:0] adc_div_d;
    logic [7:0] filt_div_q;
    logic [7:0] filt_div_d;
    logic adc_en_q;
    logic adc_en_d;
    logic filt_en_q;
    logic filt_en_d;

    seq_pkg::seq_state_type state_q;
    seq_pkg::seq_state_type state_d;
    logic [8:0] wait_cnt_q;
    logic [8:0] wait_cnt_d;
    logic trigger;
    logic seq_restart;
    logic [2:0] rx_code;
    logic [3:0] cs_code;
    logic [8:0] rx_limit;
    logic [8:0] cs_limit;

    pin_sync #(
        .N(4)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in({carrier_sense, pll_lock, data_io_pin, select_pin}),
        .level(pin_level),
        .fall(pin_fall)
    );

    restart_ctrl u_restart_ctrl (
        .sys_clk(sys_clk),
        .rst(rst),
        .rif(rif.ctrl)
    );

    // Bus slave: writes take no wait state, reads take one
    assign addr_accept = hsel & hready & htrans[1];
    assign reg_write = dp_valid_q & dp_write_q;

    always_comb
    begin
        dp_valid_d = dp_valid_q;
        dp_write_d = dp_write_q;
        dp_addr_d = dp_addr_q;
        rd_wait_d = 1'b0;
        hrdata_d = hrdata_q;
        if (hreadyout)
        begin
            dp_valid_d = 1'b0;
        end
        if (addr_accept)
        begin
            dp_valid_d = 1'b1;
            dp_write_d = hwrite;
            dp_addr_d = {haddr[11:2], 2'b00};
            rd_wait_d = ~hwrite;
        end
        if (rd_wait_q)
        begin
            case (dp_addr_q)
                seq_pkg::RESET_CTRL_ADDR: hrdata_d = {24'h000000, ~rif.pending};
                seq_pkg::SEQ_CFG_ADDR: hrdata_d = {24'h000000, seq_cfg_q};
                seq_pkg::MODE_CTRL_ADDR: hrdata_d = {29'h00000000, mode_ctrl_q};
                seq_pkg::SEQ_STATUS_ADDR:
                    hrdata_d = {27'h0000000, rx_power_up, synth_power_up, state_q};
                seq_pkg::RESET_DONE_ADDR: hrdata_d = {24'h000000, rif.done};
                default: hrdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            dp_valid_q <= 1'b0;
            dp_write_q <= 1'b0;
            dp_addr_q <= 12'h000;
            rd_wait_q <= 1'b0;
            hrdata_q <= 32'h00000000;
        end
        else
        begin
            dp_valid_q <= dp_valid_d;
            dp_write_q <= dp_write_d;
            dp_addr_q <= dp_addr_d;
            rd_wait_q <= rd_wait_d;
            hrdata_q <= hrdata_d;
        end
    end

    assign hreadyout = ~rd_wait_q;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    // Register file
    always_comb
    begin
        seq_cfg_d = seq_cfg_q;
        mode_ctrl_d = mode_ctrl_q;
        if (reg_write && dp_addr_q == seq_pkg::SEQ_CFG_ADDR)
        begin
            seq_cfg_d = hwdata[7:0];
        end
        if (reg_write && dp_addr_q == seq_pkg::MODE_CTRL_ADDR)
        begin
            mode_ctrl_d = hwdata[2:0];
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            seq_cfg_q <= seq_pkg::SEQ_CFG_RESET;
            mode_ctrl_q <= seq_pkg::MODE_CTRL_RESET;
        end
        else
        begin
            seq_cfg_q <= seq_cfg_d;
            mode_ctrl_q <= mode_ctrl_d;
        end
    end

    assign rif.wr_stb = reg_write && dp_addr_q == seq_pkg::RESET_CTRL_ADDR;
    assign rif.wr_data = hwdata[7:0];
    assign rif.clk_run = subblock_clk_run;

    assign adc_ctrl_restart_low = rif.restart_low[7];
    assign gain_ctrl_restart_low = rif.restart_low[6];
    assign shaping_filter_restart_low = rif.restart_low[5];
    assign freq_track_restart_low = rif.restart_low[4];
    assign modulator_sync_restart_low = rif.restart_low[3];
    assign synthesizer_restart_low = rif.restart_low[2];
    assign sequencer_restart_low = rif.restart_low[1];
    assign cal_lock_restart_low = rif.restart_low[0];
    assign seq_restart = ~rif.restart_low[seq_pkg::SEQ_RESTART_BIT];

    // Enable pulses standing for the ADC and filter clocks
    always_comb
    begin
        adc_div_d = adc_div_q + 8'h01;
        adc_en_d = 1'b0;
        filt_div_d = filt_div_q + 8'h01;
        filt_en_d = 1'b0;
        if (adc_div_q == seq_pkg::ADC_CLK_DIV - 8'h01)
        begin
            adc_div_d = 8'h00;
            adc_en_d = 1'b1;
        end
        if (filt_div_q == seq_pkg::FILTER_CLK_DIV - 8'h01)
        begin
            filt_div_d = 8'h00;
            filt_en_d = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            adc_div_q <= 8'h00;
            filt_div_q <= 8'h00;
            adc_en_q <= 1'b0;
            filt_en_q <= 1'b0;
        end
        else
        begin
            adc_div_q <= adc_div_d;
            filt_div_q <= filt_div_d;
            adc_en_q <= adc_en_d;
            filt_en_q <= filt_en_d;
        end
    end

    // Start condition for a sequencing run
    always_comb
    begin
        trigger = 1'b0;
        if (mode_ctrl_q[1:0] == seq_pkg::POWER_DOWN_MODE_SEL_SEQUENCED)
        begin
            if (seq_cfg_q[seq_pkg::SEL_TRIG_BIT])
            begin
                trigger = pin_fall[0];
            end
            else
            begin
                trigger = pin_fall[1] & mode_ctrl_q[seq_pkg::SPLIT_PINS_BIT];
            end
        end
    end

    assign rx_code = seq_cfg_q[seq_pkg::RX_WAIT_LSB +: 3];
    assign cs_code = seq_cfg_q[seq_pkg::CS_WAIT_LSB +: 4];
    assign rx_limit = (rx_code == seq_pkg::RX_WAIT_NONE) ? 9'h000
                                                         : seq_pkg::RX_WAIT_PERIODS[rx_code];
    assign cs_limit = seq_pkg::CS_WAIT_PERIODS[cs_code];

    // Power-up sequencer
    always_comb
    begin
        state_d = state_q;
        wait_cnt_d = wait_cnt_q;
        case (state_q)
            seq_pkg::SEQ_IDLE:
            begin
                if (trigger)
                begin
                    state_d = seq_pkg::SEQ_WAIT_LOCK;
                    wait_cnt_d = 9'h000;
                end
            end
            seq_pkg::SEQ_WAIT_LOCK:
            begin
                if (pin_level[2])
                begin
                    wait_cnt_d = 9'h000;
                    if (rx_code == seq_pkg::RX_WAIT_NONE)
                    begin
                        state_d = seq_pkg::SEQ_CS_WAIT;
                    end
                    else
                    begin
                        state_d = seq_pkg::SEQ_RX_WAIT;
                    end
                end
            end
            seq_pkg::SEQ_RX_WAIT:
            begin
                if (wait_cnt_q >= rx_limit)
                begin
                    state_d = seq_pkg::SEQ_CS_WAIT;
                    wait_cnt_d = 9'h000;
                end
                else if (adc_en_q)
                begin
                    wait_cnt_d = wait_cnt_q + 9'h001;
                end
            end
            seq_pkg::SEQ_CS_WAIT:
            begin
                if (pin_level[3])
                begin
                    state_d = seq_pkg::SEQ_RX_HOLD;
                end
                else if (wait_cnt_q >= cs_limit)
                begin
                    state_d = seq_pkg::SEQ_IDLE;
                    wait_cnt_d = 9'h000;
                end
                else if (filt_en_q)
                begin
                    wait_cnt_d = wait_cnt_q + 9'h001;
                end
            end
            seq_pkg::SEQ_RX_HOLD:
            begin
                // Receiver stays up while the carrier is present
                if (!pin_level[3])
                begin
                    state_d = seq_pkg::SEQ_IDLE;
                end
            end
            default:
            begin
                state_d = seq_pkg::SEQ_IDLE;
                wait_cnt_d = 9'h000;
            end
        endcase
        if (mode_ctrl_q[1:0] != seq_pkg::POWER_DOWN_MODE_SEL_SEQUENCED)
        begin
            state_d = seq_pkg::SEQ_IDLE;
        end
        if (seq_restart)
        begin
            state_d = seq_pkg::SEQ_IDLE;
            wait_cnt_d = 9'h000;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= seq_pkg::SEQ_IDLE;
            wait_cnt_q <= 9'h000;
        end
        else
        begin
            state_q <= state_d;
            wait_cnt_q <= wait_cnt_d;
        end
    end

    assign synth_power_up = state_q != seq_pkg::SEQ_IDLE;
    assign rx_power_up = state_q == seq_pkg::SEQ_CS_WAIT || state_q == seq_pkg::SEQ_RX_HOLD;
endmodule // subblock_reset_and_powerup_seq
`default_nettype wire

// ---- hw/seq_pkg.sv ----
// Constants and types shared by the sub-block reset and power-up sequencing design
`default_nettype none
package seq_pkg;
    localparam int unsigned NUM_SUBBLOCKS = 8;
    // Register indices as printed; byte address is four times the index
    localparam logic [9:0] RESET_CTRL_IDX = 10'h002;
    localparam logic [9:0] SEQ_CFG_IDX = 10'h003;
    localparam logic [9:0] MODE_CTRL_IDX = 10'h010;
    localparam logic [9:0] SEQ_STATUS_IDX = 10'h011;
    localparam logic [9:0] RESET_DONE_IDX = 10'h041;
    localparam logic [11:0] RESET_CTRL_ADDR = {RESET_CTRL_IDX, 2'b00};
    localparam logic [11:0] SEQ_CFG_ADDR = {SEQ_CFG_IDX, 2'b00};
    localparam logic [11:0] MODE_CTRL_ADDR = {MODE_CTRL_IDX, 2'b00};
    localparam logic [11:0] SEQ_STATUS_ADDR = {SEQ_STATUS_IDX, 2'b00};
    localparam logic [11:0] RESET_DONE_ADDR = {RESET_DONE_IDX, 2'b00};
    // Field positions
    localparam int unsigned SEL_TRIG_BIT = 7;
    localparam int unsigned RX_WAIT_LSB = 4;
    localparam int unsigned CS_WAIT_LSB = 0;
    localparam int unsigned SEQ_RESTART_BIT = 1;
    localparam int unsigned SPLIT_PINS_BIT = 2;
    // Reset values and field codes
    localparam logic [7:0] SEQ_CFG_RESET = 8'h8A;
    localparam logic [2:0] MODE_CTRL_RESET = 3'h0;
    localparam logic [1:0] POWER_DOWN_MODE_SEL_SEQUENCED = 2'h3;
    localparam logic [2:0] RX_WAIT_NONE = 3'h7;
    // Enable-pulse dividers standing for the ADC and filter clocks
    localparam logic [7:0] ADC_CLK_DIV = 8'h10;
    localparam logic [7:0] FILTER_CLK_DIV = 8'h20;
    // Wait lengths in periods of the respective clock
    localparam logic [8:0] RX_WAIT_PERIODS [0:6] = '{
        9'h020, 9'h02C, 9'h040, 9'h058, 9'h080, 9'h0B0, 9'h100};
    localparam logic [8:0] CS_WAIT_PERIODS [0:15] = '{
        9'h014, 9'h016, 9'h018, 9'h01A, 9'h01C, 9'h01E, 9'h020, 9'h024,
        9'h028, 9'h02C, 9'h030, 9'h034, 9'h042, 9'h03C, 9'h040, 9'h048};

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_WAIT_LOCK = 3'b001,
        SEQ_RX_WAIT = 3'b010,
        SEQ_CS_WAIT = 3'b011,
        SEQ_RX_HOLD = 3'b100
    } seq_state_type;
endpackage
`default_nettype wire

// ---- hw/restart_if.sv ----
// Interface between the register block and the sub-block restart controller
`timescale 1ns/100ps
`default_nettype none
interface restart_if;
    logic wr_stb;
    logic [7:0] wr_data;
    logic [7:0] clk_run;
    logic [7:0] restart_low;
    logic [7:0] pending;
    logic [7:0] done;
    modport ctrl (input wr_stb, input wr_data, input clk_run,
                  output restart_low, output pending, output done);
    modport user (output wr_stb, output wr_data, output clk_run,
                  input restart_low, input pending, input done);
endinterface
`default_nettype wire

// ---- hw/pin_sync.sv ----
// Two-stage synchronisers with falling-edge detection for pin inputs
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
    parameter int unsigned N = 4
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [N-1:0] pin_in,
    output logic [N-1:0] level,
    output logic [N-1:0] fall
);
    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;
    logic [N-1:0] prev_q;

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_pin
            always_ff @(posedge sys_clk or posedge rst)
            begin
                if (rst)
                begin
                    meta_q[i] <= 1'b1;
                    sync_q[i] <= 1'b1;
                    prev_q[i] <= 1'b1;
                end
                else
                begin
                    meta_q[i] <= pin_in[i];
                    sync_q[i] <= meta_q[i];
                    prev_q[i] <= sync_q[i];
                end
            end
            assign level[i] = sync_q[i];
            assign fall[i] = prev_q[i] & ~sync_q[i];
        end
    endgenerate
endmodule // pin_sync
`default_nettype wire

// ---- hw/restart_ctrl.sv ----
// Self-clearing active-low restart of eight digital sub-blocks
`timescale 1ns/100ps
`default_nettype none
module restart_ctrl (
    input wire logic sys_clk,
    input wire logic rst,
    restart_if.ctrl rif
);
    logic [7:0] pending_q;
    logic [7:0] pending_d;
    logic [7:0] pulse_q;
    logic [7:0] pulse_d;
    logic [7:0] done_q;
    logic [7:0] done_d;

    genvar i;
    generate
        for (i = 0; i < seq_pkg::NUM_SUBBLOCKS; i++)
        begin : g_bit
            always_comb
            begin
                pending_d[i] = pending_q[i];
                pulse_d[i] = 1'b0;
                done_d[i] = done_q[i];
                if (pending_q[i] && rif.clk_run[i])
                begin
                    // Restart fires only while the sub-block clock runs
                    pending_d[i] = 1'b0;
                    pulse_d[i] = 1'b1;
                end
                if (pulse_q[i])
                begin
                    done_d[i] = 1'b1;
                end
                // A new write wins over completion in the same cycle
                if (rif.wr_stb && !rif.wr_data[i])
                begin
                    pending_d[i] = 1'b1;
                    done_d[i] = 1'b0;
                end
            end
        end
    endgenerate

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pending_q <= 8'hFF;
            pulse_q <= 8'h00;
            done_q <= 8'h00;
        end
        else
        begin
            pending_q <= pending_d;
            pulse_q <= pulse_d;
            done_q <= done_d;
        end
    end

    assign rif.restart_low = ~pulse_q;
    assign rif.pending = pending_q;
    assign rif.done = done_q;
endmodule // restart_ctrl
`default_nettype wire

// ---- testbench/seq_properties.sv ----
// Port-level checks of the sub-block reset and sequencing block
`timescale 1ns/100ps
`default_nettype none
module seq_properties (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [7:0] subblock_clk_run,
    input wire logic adc_ctrl_restart_low,
    input wire logic gain_ctrl_restart_low,
    input wire logic shaping_filter_restart_low,
    input wire logic freq_track_restart_low,
    input wire logic modulator_sync_restart_low,
    input wire logic synthesizer_restart_low,
    input wire logic sequencer_restart_low,
    input wire logic cal_lock_restart_low,
    input wire logic synth_power_up,
    input wire logic rx_power_up
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [7:0] rl;
    assign rl = {adc_ctrl_restart_low, gain_ctrl_restart_low, shaping_filter_restart_low,
        freq_track_restart_low, modulator_sync_restart_low, synthesizer_restart_low,
        sequencer_restart_low, cal_lock_restart_low};
    sequence rd_taken;
        hsel && hready && htrans[1] && !hwrite;
    endsequence
    sequence rd_answer;
        !hreadyout ##1 hreadyout;
    endsequence
    restart_one_cycle_a: assert property (rl != 8'hFF |=> (~rl & ~$past(rl)) == 8'h00)
        else $error("restart pulse longer than one cycle");
    restart_needs_clk_a: assert property ((~rl & ~$past(subblock_clk_run)) == 8'h00)
        else $error("restart without sub-block clock");
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("response not OKAY");
    read_wait_a: assert property (rd_taken |=> rd_answer)
        else $error("read answer timing wrong");
    write_nowait_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
        else $error("write data phase stalled");
    seq_restart_idle_a: assert property (!sequencer_restart_low |-> ##[0:3] !synth_power_up)
        else $error("sequencer restart left it running");
    rx_needs_synth_a: assert property (rx_power_up |-> synth_power_up)
        else $error("receiver up while sequencer idle");
    rx_after_lock_a: assert property ($rose(rx_power_up) |-> $past(synth_power_up))
        else $error("receiver up without lock wait");
endmodule // seq_properties
`default_nettype wire

// ---- testbench/radio_env.sv ----
// PLL stand-in: reports lock a fixed time after the synthesizer powers up
`timescale 1ns/100ps
`default_nettype none
module radio_env #(
    parameter int LOCK_DELAY = 20
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic synth_power_up,
    output logic pll_lock
);
    int cnt_q;
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst || !synth_power_up)
            cnt_q <= 0;
        else if (cnt_q < LOCK_DELAY)
            cnt_q <= cnt_q + 1;
    end
    assign pll_lock = (cnt_q == LOCK_DELAY);
endmodule // radio_env
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench for the sub-block reset and sequencing block
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic sys_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, carrier_sense = 1'b0;
    logic select_pin = 1'b1, data_io_pin = 1'b1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] clk_run = 8'h00;
    wire logic hreadyout, hresp, pll_lock, synth_power_up, rx_power_up;
    wire logic [31:0] hrdata;
    wire logic [7:0] rl;
    int n_mismatch = 0, comparisons = 0, t;
    int pulses [8] = '{default: 0};
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        for (int i = 0; i < 8; i++)
            if (rl[i] === 1'b0)
                pulses[i]++;
    radio_env radio_env_i (.sys_clk(sys_clk), .rst(rst), .synth_power_up(synth_power_up),
        .pll_lock(pll_lock));
    subblock_reset_and_powerup_seq subblock_reset_and_powerup_seq_i (.sys_clk(sys_clk),
        .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .select_pin(select_pin), .data_io_pin(data_io_pin),
        .pll_lock(pll_lock), .carrier_sense(carrier_sense), .subblock_clk_run(clk_run),
        .adc_ctrl_restart_low(rl[7]), .gain_ctrl_restart_low(rl[6]),
        .shaping_filter_restart_low(rl[5]), .freq_track_restart_low(rl[4]),
        .modulator_sync_restart_low(rl[3]), .synthesizer_restart_low(rl[2]),
        .sequencer_restart_low(rl[1]), .cal_lock_restart_low(rl[0]),
        .synth_power_up(synth_power_up), .rx_power_up(rx_power_up));
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        comparisons++;
        if (got < lo || got > hi)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask
    // One single AHB transfer; read data lands in rd
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {20'h00000, a};
        do @(posedge sys_clk); while (hreadyout !== 1'b1 && ++n < 100);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge sys_clk); while (hreadyout !== 1'b1 && ++n < 100);
        rd = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic poll_done();
        int n;
        n = 0;
        do ahb(1'b0, seq_pkg::RESET_DONE_ADDR, 32'h0); while (rd !== 32'hFF && ++n < 20);
        chk(rd, 32'hFF);
    endtask
    function automatic logic sig(input int k);
        return k == 0 ? pll_lock : (k == 1 ? rx_power_up : synth_power_up);
    endfunction
    task automatic wait_lvl(input int k, input logic v, input int lim);
        t = 0;
        while (sig(k) !== v && t < lim)
        begin
            @(posedge sys_clk);
            t++;
        end
    endtask
    task automatic fall(input logic s, input logic d);
        select_pin <= ~s;
        data_io_pin <= ~d;
        repeat (4) @(posedge sys_clk);
        select_pin <= 1'b1;
        data_io_pin <= 1'b1;
    endtask
    task automatic seq_run(input int rx, input int cs);
        int e;
        wr(seq_pkg::SEQ_CFG_ADDR, {24'h0, 1'b1, rx[2:0], cs[3:0]});
        fall(1'b1, 1'b0);
        wait_lvl(0, 1'b1, 500);
        wait_lvl(1, 1'b1, 6000);
        e = int'(seq_pkg::RX_WAIT_PERIODS[rx % 7]) * int'(seq_pkg::ADC_CLK_DIV);
        if (rx == 7)
            chk_rng(t, 0, 8);
        else
            chk_rng(t, e - 16, e + 24);
        e = int'(seq_pkg::CS_WAIT_PERIODS[cs]) * int'(seq_pkg::FILTER_CLK_DIV);
        wait_lvl(1, 1'b0, 3000);
        chk_rng(t, e - 32, e + 40);
    endtask
    initial
    begin
        repeat (6) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        rdc(seq_pkg::SEQ_CFG_ADDR, 32'h8A);
        rdc(seq_pkg::RESET_CTRL_ADDR, 32'h0);
        rdc(seq_pkg::RESET_DONE_ADDR, 32'h0);
        clk_run <= 8'hFF;
        poll_done();
        rdc(seq_pkg::RESET_CTRL_ADDR, 32'hFF);
        for (int i = 0; i < 8; i++)
        begin
            clk_run <= ~(8'h01 << i);
            wr(seq_pkg::RESET_CTRL_ADDR, {24'h0, ~(8'h01 << i)});
            rdc(seq_pkg::RESET_CTRL_ADDR, {24'h0, ~(8'h01 << i)});
            chk(pulses[i], 1);
            clk_run <= 8'hFF;
            poll_done();
            chk(pulses[i], 2);
            chk(pulses.sum(), 9 + i);
        end
        wr(12'h200, 32'hFF);
        rdc(12'h200, 32'h0);
        fall(1'b1, 1'b1);
        wait_lvl(2, 1'b1, 50);
        chk(synth_power_up, 1'b0);
        wr(seq_pkg::MODE_CTRL_ADDR, 32'h3);
        wr(seq_pkg::SEQ_CFG_ADDR, 32'h0A);
        fall(1'b1, 1'b1);
        wait_lvl(2, 1'b1, 50);
        chk(synth_power_up, 1'b0);
        wr(seq_pkg::MODE_CTRL_ADDR, 32'h7);
        rdc(seq_pkg::MODE_CTRL_ADDR, 32'h7);
        fall(1'b0, 1'b1);
        wait_lvl(2, 1'b1, 50);
        chk(synth_power_up, 1'b1);
        wait_lvl(1, 1'b1, 6000);
        rdc(seq_pkg::SEQ_STATUS_ADDR, 32'h1B);
        wr(seq_pkg::RESET_CTRL_ADDR, 32'hFD);
        wait_lvl(2, 1'b0, 4);
        chk(synth_power_up, 1'b0);
        poll_done();
        for (int c = 0; c < 16; c++)
            seq_run(c % 8, c);
        wr(seq_pkg::SEQ_CFG_ADDR, 32'hF0);
        fall(1'b1, 1'b0);
        wait_lvl(1, 1'b1, 500);
        carrier_sense <= 1'b1;
        repeat (1000) @(posedge sys_clk);
        chk(rx_power_up, 1'b1);
        carrier_sense <= 1'b0;
        wait_lvl(1, 1'b0, 700);
        chk(rx_power_up, 1'b0);
        wrap_up();
    end
    initial
    begin
        #(8 * 80000);
        n_mismatch++;
        wrap_up();
    end
endmodule // tb
bind subblock_reset_and_powerup_seq seq_properties seq_properties_i (.sys_clk(sys_clk),
    .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .subblock_clk_run(subblock_clk_run),
    .adc_ctrl_restart_low(adc_ctrl_restart_low), .gain_ctrl_restart_low(gain_ctrl_restart_low),
    .shaping_filter_restart_low(shaping_filter_restart_low),
    .freq_track_restart_low(freq_track_restart_low),
    .modulator_sync_restart_low(modulator_sync_restart_low),
    .synthesizer_restart_low(synthesizer_restart_low),
    .sequencer_restart_low(sequencer_restart_low), .cal_lock_restart_low(cal_lock_restart_low),
    .synth_power_up(synth_power_up), .rx_power_up(rx_power_up));
`default_nettype wire
